/* File: pcm_consts.svh */
// Constants of the PWM channel mapper: timing, codes, reset values.
// Assumes a 50 MHz system clock; included by pcm_role and pcm_map.
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH
// Function
// RULE1: Three channels, each fed by its own pin
// RULE2: Disabled channel never switches any bridge
// RULE3: Mode 01 maps channel onto low side
// RULE4: Mode 10 maps channel onto high side
// RULE5: Modes 00 and 11 block all switching
// RULE6: Mode 00 bridge stays off despite mapping
// RULE7: Double mapping: error, bridge off, status set
// RULE8: Opposite switch on while active one off
// RULE9: Check off: PWM switch counts as active
// RULE10: Check on: roles decided after protection gap
// RULE11: Node above high threshold: high side freewheels
// RULE12: Node below low threshold: low side freewheels
// RULE13: Node in between: switch turning on active
// RULE14: PWM always drives the mode-chosen switch
// RULE15: Pulse shorter than gap: PWM switch active
// RULE16: Adaptive scheme applies pre-charge and pre-discharge
// RULE17: Scheme 00 skips both pre phases
// RULE18: Scheme 01 fixed-current pre-discharge only
// RULE19: Mapping works only with pass-through off
// RULE20: Settings apply within 3 us after select
// RULE21: PWM pins synchronised before use
// RULE22: Software: mode 00, then mapping, then mode
`define PCM_CLK_MHZ       50
`define PCM_APPLY_MAX_NS  3000
`define PCM_APPLY_MAX_CYC ((`PCM_APPLY_MAX_NS * `PCM_CLK_MHZ) / 1000)
`define PCM_CCP_ACT_NS    500
`define PCM_CCP_ACT_CYC   ((`PCM_CCP_ACT_NS * `PCM_CLK_MHZ + 999) / 1000)
`define PCM_CCP_FW_NS     500
`define PCM_CCP_FW_CYC    ((`PCM_CCP_FW_NS * `PCM_CLK_MHZ + 999) / 1000)
`define PCM_NUM_CH        3
`define PCM_NUM_HB        8
`define PCM_CNT_W         16
`define PCM_IPD_W         6
`define PCM_MODE_OFF      2'h0
`define PCM_MODE_LS       2'h1
`define PCM_MODE_HS       2'h2
`define PCM_MODE_OFF2     2'h3
`define PCM_AGC_NONE      2'h0
`define PCM_AGC_FIXED     2'h1
`define PCM_AGC_ADAPT_BIT 1
`define PCM_RST_EN        3'h0
`define PCM_RST_SEL       9'h000
`define PCM_RST_MODE      16'h0000
`define PCM_RST_AGC       2'h0
`endif

/* File: pcm_pkg.sv */
// Types shared by the PWM channel mapper modules.
// Assumes pcm_consts.svh is on the include path.
`default_nettype none
package pcm_pkg;
	typedef logic [2:0] pcm_sel_type;
	typedef logic [1:0] pcm_mode_type;
	typedef enum logic [1:0] {RS_IDLE, RS_GAP, RS_ON} pcm_role_state_type;
endpackage
`default_nettype wire

/* File: pcm_bridge_if.sv */
// Link between the mapper and one half-bridge sequencer.
// Assumes one instance per half-bridge, all on sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface pcm_bridge_if;
	logic mapped;
	logic pwm;
	logic pwm_high;
	logic gen_check;
	logic above_h;
	logic below_l;
	logic hs_on;
	logic ls_on;
	logic act_high;
	modport ctl (output mapped, pwm, pwm_high, gen_check, above_h, below_l,
		input hs_on, ls_on, act_high);
	modport drv (input mapped, pwm, pwm_high, gen_check, above_h, below_l,
		output hs_on, ls_on, act_high);
endinterface
`default_nettype wire

/* File: pcm_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the inputs may change at any time relative to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pcm_sync #(
	parameter int W = 4
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s1_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d; // see RULE21
			q    <= s1_q;
		end
	end
endmodule
`default_nettype wire

/* File: pcm_role.sv */
// Sequencer of one half-bridge in PWM mode with active freewheeling.
// Assumes synchronised PWM level and comparator levels from the mapper.
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.svh"
module pcm_role #(
	parameter int CCP_ACT_CYC = `PCM_CCP_ACT_CYC,
	parameter int CCP_FW_CYC  = `PCM_CCP_FW_CYC
) (
	input wire logic   sys_clk,
	input wire logic   nrst,
	pcm_bridge_if.drv  br
);
	import pcm_pkg::*;
	localparam logic [`PCM_CNT_W-1:0] ACT_M1 = `PCM_CNT_W'(CCP_ACT_CYC - 1);
	localparam logic [`PCM_CNT_W-1:0] FW_M1  = `PCM_CNT_W'(CCP_FW_CYC - 1);

	pcm_role_state_type     state_q;
	logic [`PCM_CNT_W-1:0]  cnt_q;
	logic                   hs_q;
	logic                   ls_q;
	logic                   act_q;
	logic                   prev_q;
	logic                   short_q;
	logic                   tgt_high;
	logic                   done;

	assign tgt_high = br.pwm ? br.pwm_high : !br.pwm_high; // see RULE14
	assign done     = state_q == RS_GAP && cnt_q == '0 && br.pwm == prev_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			prev_q <= 1'b0;
		else
			prev_q <= br.pwm;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_q <= RS_IDLE;
			cnt_q   <= '0;
			hs_q    <= 1'b0;
			ls_q    <= 1'b0;
			act_q   <= 1'b0;
			short_q <= 1'b0;
		end else if (!br.mapped) begin
			state_q <= RS_IDLE;
			cnt_q   <= '0;
			hs_q    <= 1'b0;
			ls_q    <= 1'b0;
			act_q   <= br.pwm_high;
			short_q <= 1'b0;
		end else begin
			case (state_q)
			RS_IDLE, RS_ON: begin
				// A mode flip while on re-runs the gap as well
				if (state_q == RS_IDLE || br.pwm != prev_q || hs_q != tgt_high) begin // see RULE14
					// Both off first: no cross conduction on any edge
					hs_q    <= 1'b0;
					ls_q    <= 1'b0;
					state_q <= RS_GAP;
					cnt_q   <= br.pwm ? FW_M1 : ACT_M1;
					short_q <= 1'b0;
				end
			end
			RS_GAP: begin
				if (br.pwm != prev_q) begin
					cnt_q   <= br.pwm ? FW_M1 : ACT_M1;
					short_q <= 1'b1; // see RULE15
				end else if (cnt_q != '0) begin
					cnt_q <= cnt_q - `PCM_CNT_W'(1);
				end else begin
					state_q <= RS_ON;
					hs_q    <= tgt_high; // see RULE8
					ls_q    <= !tgt_high;
					if (!br.gen_check || short_q)
						act_q <= br.pwm_high; // see RULE9
					else if (br.above_h)
						act_q <= 1'b0; // see RULE10 see RULE11
					else if (br.below_l)
						act_q <= 1'b1; // see RULE12
					else
						act_q <= tgt_high; // see RULE13
				end
			end
			default: state_q <= RS_IDLE;
			endcase
		end
	end

	assign br.hs_on    = hs_q;
	assign br.ls_on    = ls_q;
	assign br.act_high = act_q;

	no_cross_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE8
		!(hs_q && ls_q)) else $error("both switches of a bridge on");
	fw_turn_on_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE8
		done && !br.pwm && br.mapped |=> ls_q == $past(br.pwm_high) && hs_q != ls_q)
		else $error("freewheel switch not turned on after gap");
	role_default_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE9
		done && br.mapped && !br.gen_check |=> act_q == $past(br.pwm_high))
		else $error("PWM switch not taken as active");
	role_high_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE11
		done && br.mapped && br.gen_check && !short_q && br.above_h |=> !act_q)
		else $error("high node voltage gave wrong roles");
endmodule
`default_nettype wire

/* File: pcm_map.sv */
// Top of the PWM channel mapper: three pins onto eight half-bridges.
// Assumes configuration ports are held stable by the serial register
// block and chip_select_pin rises at the end of each write frame.
`timescale 1ns/100ps
`default_nettype none
`include "pcm_consts.svh"
module pcm_map #(
	parameter int CCP_ACT_CYC = `PCM_CCP_ACT_CYC,
	parameter int CCP_FW_CYC  = `PCM_CCP_FW_CYC,
	parameter int IPD_W       = `PCM_IPD_W
) (
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	input  wire logic                     pulse_input_pin_one,
	input  wire logic                     pulse_input_pin_two,
	input  wire logic                     pulse_input_pin_three,
	input  wire logic                     chip_select_pin,
	input  wire logic [2:0]               channel_enable_bit,
	input  wire pcm_pkg::pcm_sel_type [2:0]  channel_bridge_select,
	input  wire pcm_pkg::pcm_mode_type [7:0] bridge_mode_field,
	input  wire logic                     generator_check_enable,
	input  wire logic [1:0]               gate_control_scheme,
	input  wire logic                     bridge_pass_through,
	input  wire logic [IPD_W-1:0]         initial_predischarge_current,
	input  wire logic [7:0]               switch_node_above_high,
	input  wire logic [7:0]               switch_node_below_low,
	input  wire logic [7:0]               status_clear,
	output logic      [7:0]               high_side_gate_on,
	output logic      [7:0]               low_side_gate_on,
	output logic      [7:0]               bridge_active_is_high,
	output logic      [7:0]               bridge_output_error_status,
	output logic                          spi_error_flag,
	output logic      [2:0]               precharge_phase,
	output logic      [2:0]               predischarge_phase,
	output logic      [2:0]               predischarge_fixed,
	output logic      [IPD_W-1:0]         predischarge_current
);
	import pcm_pkg::*;

	// Synchronised pins: three channels plus chip select
	logic [3:0]              pin_s;
	logic                    cs_prev_q;
	logic                    apply_q;
	logic [2:0]              ch_prev_q;

	// Shadow copy, loaded only once a write frame has ended
	logic [2:0]              cfg_en_q;
	pcm_sel_type [2:0]       cfg_sel_q;
	pcm_mode_type [7:0]      cfg_mode_q;
	logic                    cfg_gen_q;
	logic [1:0]              cfg_agc_q;
	logic                    cfg_pass_q;
	logic [IPD_W-1:0]        cfg_ipd_q;

	logic [7:0]              mapped;
	logic [7:0]              conflict;
	logic [7:0]              bpwm;
	logic [2:0]              ch_live;
	logic [2:0]              ch_rise;
	logic [2:0]              ch_fall;
	logic [7:0]              err_q;
	logic [7:0]              err_d;
	logic                    spi_err_q;
	logic [2:0]              pre_q;
	logic [2:0]              pdis_q;
	logic [2:0]              pfix_q;
	logic [IPD_W-1:0]        pcur_q;
	logic                    agc_adapt;
	logic                    agc_any;
	logic                    agc_fixed;
	logic                    cs_raw_q;
	logic [7:0]              apply_wait_q;

	// Number of enabled channels pointing at bridge b
	function automatic logic [1:0] pcm_hits(
		input logic [2:0]        en,
		input pcm_sel_type [2:0] sel,
		input logic [2:0]        b
	);
		logic [1:0] n;
		n = 2'h0;
		for (int c = 0; c < `PCM_NUM_CH; c++) begin
			if (en[c] && sel[c] == b)
				n = n + 2'h1;
		end
		return n;
	endfunction

	// PWM level of the enabled channel pointing at bridge b
	function automatic logic pcm_pick(
		input logic [2:0]        en,
		input pcm_sel_type [2:0] sel,
		input logic [2:0]        lvl,
		input logic [2:0]        b
	);
		logic p;
		p = 1'b0;
		for (int c = 0; c < `PCM_NUM_CH; c++) begin
			if (en[c] && sel[c] == b)
				p = p | lvl[c];
		end
		return p;
	endfunction

	pcm_sync #(
		.W (4)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.d       ({chip_select_pin, pulse_input_pin_three, pulse_input_pin_two,
			pulse_input_pin_one}), // see RULE1 see RULE21
		.q       (pin_s)
	);

	// Chip select rise, seen after the synchroniser
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cs_prev_q <= 1'b0;
			apply_q   <= 1'b0;
		end else begin
			cs_prev_q <= pin_s[3];
			apply_q   <= pin_s[3] && !cs_prev_q; // see RULE20
		end
	end

	// Settings change only between frames, so a half-written
	// mapping can never reach the gates
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cfg_en_q   <= `PCM_RST_EN;
			cfg_sel_q  <= `PCM_RST_SEL;
			cfg_mode_q <= `PCM_RST_MODE;
			cfg_gen_q  <= 1'b0;
			cfg_agc_q  <= `PCM_RST_AGC;
			cfg_pass_q <= 1'b0;
			cfg_ipd_q  <= '0;
		end else if (apply_q) begin
			cfg_en_q   <= channel_enable_bit; // see RULE20
			cfg_sel_q  <= channel_bridge_select;
			cfg_mode_q <= bridge_mode_field;
			cfg_gen_q  <= generator_check_enable;
			cfg_agc_q  <= gate_control_scheme;
			cfg_pass_q <= bridge_pass_through;
			cfg_ipd_q  <= initial_predischarge_current;
		end
	end

	// Bridge decode from the shadow settings
	always_comb begin
		logic [1:0] hits;
		hits     = 2'h0;
		mapped   = '0;
		conflict = '0;
		bpwm     = '0;
		for (int b = 0; b < `PCM_NUM_HB; b++) begin
			hits        = pcm_hits(cfg_en_q, cfg_sel_q, 3'(b)); // see RULE2 see RULE3
			conflict[b] = !cfg_pass_q && hits > 2'h1; // see RULE7
			mapped[b]   = !cfg_pass_q && hits == 2'h1 // see RULE19
				&& (cfg_mode_q[b] == `PCM_MODE_LS // see RULE3
				|| cfg_mode_q[b] == `PCM_MODE_HS); // see RULE4 see RULE5 see RULE6 see RULE22
			bpwm[b]     = pcm_pick(cfg_en_q, cfg_sel_q, pin_s[2:0], 3'(b));
		end
	end

	// A channel is live when its bridge really switches
	always_comb begin
		for (int c = 0; c < `PCM_NUM_CH; c++)
			ch_live[c] = cfg_en_q[c] && mapped[cfg_sel_q[c]];
	end

	assign ch_rise = pin_s[2:0] & ~ch_prev_q;
	assign ch_fall = ~pin_s[2:0] & ch_prev_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			ch_prev_q <= '0;
		else
			ch_prev_q <= pin_s[2:0];
	end

	// Per-bridge sequencers
	for (genvar b = 0; b < `PCM_NUM_HB; b++) begin : g_hb
		pcm_bridge_if br ();

		assign br.mapped    = mapped[b];
		assign br.pwm       = bpwm[b];
		assign br.pwm_high  = cfg_mode_q[b] == `PCM_MODE_HS; // see RULE4 see RULE14
		assign br.gen_check = cfg_gen_q; // see RULE9 see RULE10
		assign br.above_h   = switch_node_above_high[b];
		assign br.below_l   = switch_node_below_low[b];

		pcm_role #(
			.CCP_ACT_CYC (CCP_ACT_CYC),
			.CCP_FW_CYC  (CCP_FW_CYC)
		) u_role (
			.sys_clk (sys_clk),
			.nrst    (nrst),
			.br      (br.drv)
		);

		assign high_side_gate_on[b]     = br.hs_on;
		assign low_side_gate_on[b]      = br.ls_on;
		assign bridge_active_is_high[b] = br.act_high;

		mode_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE5
			(cfg_mode_q[b] == `PCM_MODE_OFF || cfg_mode_q[b] == `PCM_MODE_OFF2)
			|=> !high_side_gate_on[b] && !low_side_gate_on[b])
			else $error("bridge switches in an off mode");
		conflict_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE7
			conflict[b] |=> err_q[b] && spi_err_q
			&& !high_side_gate_on[b] && !low_side_gate_on[b])
			else $error("doubly mapped bridge not shut off and flagged");
		lowside_map_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE3
			mapped[b] && cfg_mode_q[b] == `PCM_MODE_LS |=> !high_side_gate_on[b]
			|| !$past(bpwm[b]))
			else $error("high side driven while PWM asks low side on");
		highside_map_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE4
			mapped[b] && cfg_mode_q[b] == `PCM_MODE_HS |=> !low_side_gate_on[b]
			|| !$past(bpwm[b]))
			else $error("low side driven while PWM asks high side on");
		unmapped_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE2
			!mapped[b] |=> !high_side_gate_on[b] && !low_side_gate_on[b])
			else $error("unmapped bridge still switching");
		err_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE7
			err_q[b] && !status_clear[b] |=> err_q[b])
			else $error("mapping error bit lost without a clear");
		err_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE7
			!conflict[b] && status_clear[b] |=> !err_q[b])
			else $error("mapping error bit not cleared");
	end

	// Mapping errors: sticky, a new conflict beats a clear
	assign err_d = (err_q & ~status_clear) | conflict; // see RULE7

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			err_q     <= '0;
			spi_err_q <= 1'b0;
		end else begin
			err_q     <= err_d;
			spi_err_q <= |err_d;
		end
	end

	assign bridge_output_error_status = err_q;
	assign spi_error_flag             = spi_err_q;

	// Gate control scheme decode
	assign agc_adapt = cfg_agc_q[`PCM_AGC_ADAPT_BIT];
	assign agc_any   = cfg_agc_q != `PCM_AGC_NONE;
	assign agc_fixed = cfg_agc_q == `PCM_AGC_FIXED;

	// Phase strobes for the current regulator; the currents themselves
	// are set outside, this block times the phases and passes on the fixed pre-discharge current
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pre_q  <= '0;
			pdis_q <= '0;
			pfix_q <= '0;
			pcur_q <= '0;
		end else begin
			pre_q  <= ch_rise & ch_live & {3{agc_adapt}}; // see RULE16 see RULE17
			pdis_q <= ch_fall & ch_live & {3{agc_any}}; // see RULE16 see RULE18
			pfix_q <= ch_live & {3{agc_fixed}}; // see RULE18
			pcur_q <= agc_fixed ? cfg_ipd_q : '0; // see RULE18
		end
	end

	assign precharge_phase      = pre_q;
	assign predischarge_phase   = pdis_q;
	assign predischarge_fixed   = pfix_q;
	assign predischarge_current = pcur_q;

	// Time since the last chip select rise at the pin, for the bound check
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cs_raw_q     <= 1'b0;
			apply_wait_q <= 8'h00;
		end else begin
			cs_raw_q <= chip_select_pin;
			if (apply_q)
				apply_wait_q <= 8'h00;
			else if (chip_select_pin && !cs_raw_q)
				apply_wait_q <= 8'h01;
			else if (apply_wait_q != 8'h00)
				apply_wait_q <= apply_wait_q + 8'h01;
		end
	end

	sequence cs_rise_s;
		$rose(chip_select_pin);
	endsequence

	sequence idle_cfg_s;
		cfg_en_q == 3'h0 ##1 cfg_en_q == 3'h0;
	endsequence

	sequence pass_cfg_s;
		cfg_pass_q ##1 cfg_pass_q;
	endsequence

	apply_latency_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE20
		cs_rise_s ##1 chip_select_pin ##1 chip_select_pin |-> ##[0:2] apply_q)
		else $error("settings not applied after chip select rise");
	disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE2
		idle_cfg_s |-> (high_side_gate_on | low_side_gate_on) == 8'h00)
		else $error("gate switching with all channels disabled");
	pass_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE19
		pass_cfg_s |-> (high_side_gate_on | low_side_gate_on) == 8'h00)
		else $error("mapping active under pass-through");
	scheme_none_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE17
		cfg_agc_q == `PCM_AGC_NONE |=> precharge_phase == 3'h0
		&& predischarge_phase == 3'h0)
		else $error("pre phase with scheme none");
	scheme_fixed_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE18
		agc_fixed |=> precharge_phase == 3'h0
		&& predischarge_current == $past(cfg_ipd_q))
		else $error("fixed scheme current or pre-charge wrong");
	precharge_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE16
		agc_adapt && ch_live[0] && ch_rise[0] |=> precharge_phase[0])
		else $error("pre-charge strobe missing on adaptive rise");
	precharge_none_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE17 see RULE18
		!agc_adapt |=> precharge_phase == 3'h0)
		else $error("pre-charge strobe without adaptive scheme");
	discharge_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE16 see RULE18
		agc_any && ch_live[0] && ch_fall[0] |=> predischarge_phase[0])
		else $error("pre-discharge strobe missing on falling edge");
	fixed_current_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE18
		!agc_fixed |=> predischarge_current == '0 && predischarge_fixed == 3'h0)
		else $error("fixed pre-discharge current outside its scheme");
	spi_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE7
		spi_error_flag == |bridge_output_error_status)
		else $error("error flag differs from the status bits");
	apply_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE20
		apply_wait_q < 8'(`PCM_APPLY_MAX_CYC))
		else $error("settings not applied in time");
endmodule
`default_nettype wire

/* File: pcm_hb_model.sv */
// Far-side model: eight half-bridges whose switch nodes feed the comparators.
// Assumes gate commands from the mapper; float_kind sets the node while both are off.
`timescale 1ns/100ps
`default_nettype none
module pcm_hb_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] high_side_gate_on,
	input  wire logic [7:0] low_side_gate_on,
	input  wire logic [1:0] float_kind,
	output logic      [7:0] node_above_high,
	output logic      [7:0] node_below_low
);
	// Registered, so the comparators lag the gates by one cycle, as real ones would
	always_ff @(posedge sys_clk) begin
		for (int b = 0; b < 8; b++) begin
			if (high_side_gate_on[b] && !low_side_gate_on[b]) begin
				node_above_high[b] <= 1'b1;
				node_below_low[b]  <= 1'b0;
			end else if (low_side_gate_on[b] && !high_side_gate_on[b]) begin
				node_above_high[b] <= 1'b0;
				node_below_low[b]  <= 1'b1;
			end else begin
				// Both off: 1 node lifted, 2 node pulled down, 0 node between thresholds
				node_above_high[b] <= (float_kind == 2'h1);
				node_below_low[b]  <= (float_kind == 2'h2);
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the PWM channel mapper with a half-bridge model.
// Assumes pcm_pkg, pcm_bridge_if, the design modules and pcm_hb_model compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pcm_pkg::*;
	typedef struct {
		int           ch;
		logic         en;
		int           b;
		pcm_mode_type m;
		logic         lvl;
		logic [7:0]   hs;
		logic [7:0]   ls;
		logic [7:0]   act;
	} pcm_row_type;
	logic               sys_clk, nrst, cs, gck, pass, spi;
	logic [2:0]         pins, en, pc, pd, pdf;
	pcm_sel_type [2:0]  sel;
	pcm_mode_type [7:0] mode;
	logic [1:0]         gcs, kind;
	logic [5:0]         ipd, pdc;
	logic [7:0]         clr, above, below, hs, ls, act, err;
	int                 n_mismatch = 0, checks = 0, n_pc = 0, n_pd = 0, base_pc, base_pd;
	pcm_row_type        rows [9];

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	pcm_map #(.CCP_ACT_CYC(4), .CCP_FW_CYC(4), .IPD_W(6)) i_pcm_map (
		.sys_clk(sys_clk), .nrst(nrst), .pulse_input_pin_one(pins[0]),
		.pulse_input_pin_two(pins[1]), .pulse_input_pin_three(pins[2]),
		.chip_select_pin(cs), .channel_enable_bit(en), .channel_bridge_select(sel),
		.bridge_mode_field(mode), .generator_check_enable(gck), .gate_control_scheme(gcs),
		.bridge_pass_through(pass), .initial_predischarge_current(ipd),
		.switch_node_above_high(above), .switch_node_below_low(below), .status_clear(clr),
		.high_side_gate_on(hs), .low_side_gate_on(ls), .bridge_active_is_high(act),
		.bridge_output_error_status(err), .spi_error_flag(spi), .precharge_phase(pc),
		.predischarge_phase(pd), .predischarge_fixed(pdf), .predischarge_current(pdc));

	pcm_hb_model i_pcm_hb_model (.sys_clk(sys_clk), .high_side_gate_on(hs),
		.low_side_gate_on(ls), .float_kind(kind), .node_above_high(above),
		.node_below_low(below));

	// Counts strobes of channel one; each is one cycle wide
	always @(posedge sys_clk) begin
		n_pc <= n_pc + int'(pc[0]);
		n_pd <= n_pd + int'(pd[0]);
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Frame end; settings must be live well inside 150 cycles
	task automatic apply;
		cs = 1'b1;
		step(6);
		cs = 1'b0;
		step(6);
	endtask

	task automatic map(input int ch, input logic e, input int b, input pcm_mode_type m);
		mode = '0;
		apply;
		sel[ch] = 3'(b);
		en = {2'h0, e} << ch;
		apply;
		cmp(hs | ls, 8'h00);
		mode[b] = m;
		apply;
		step(12);
	endtask

	task automatic role(input logic [1:0] k, input logic lvl, input logic exp_act);
		kind = k;
		pins[0] = lvl;
		step(20);
		cmp(8'(act[0]), 8'(exp_act));
		cmp(8'(lvl ? hs[0] : ls[0]), 8'h01);
	endtask

	// Hang guard well beyond the whole sequence
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict;
	end

	initial begin
		rows = '{'{0, 1, 0, 2'h1, 1, 8'h00, 8'h01, 8'h00},
			'{0, 1, 0, 2'h1, 0, 8'h01, 8'h00, 8'h00},
			'{1, 1, 7, 2'h2, 1, 8'h80, 8'h00, 8'h80},
			'{1, 1, 7, 2'h2, 0, 8'h00, 8'h80, 8'h80},
			'{2, 1, 4, 2'h1, 1, 8'h00, 8'h10, 8'h00},
			'{2, 0, 4, 2'h1, 1, 8'h00, 8'h00, 8'h00},
			'{0, 1, 2, 2'h0, 1, 8'h00, 8'h00, 8'h00},
			'{0, 1, 2, 2'h3, 1, 8'h00, 8'h00, 8'h00},
			'{2, 1, 3, 2'h2, 0, 8'h00, 8'h08, 8'h08}};
		nrst = 1'b0;
		cs = 1'b0;
		gck = 1'b0;
		pass = 1'b0;
		pins = '0;
		en = '0;
		sel = '0;
		mode = '0;
		gcs = 2'h0;
		kind = 2'h0;
		ipd = 6'h00;
		clr = 8'h00;
		step(16);
		cmp(hs | ls | act | err, 8'h00);
		nrst = 1'b1;
		step(2);
		foreach (rows[i]) begin
			pins = '0;
			pins[rows[i].ch] = rows[i].lvl;
			map(rows[i].ch, rows[i].en, rows[i].b, rows[i].m);
			cmp(hs, rows[i].hs);
			cmp(ls, rows[i].ls);
			cmp(act, rows[i].act);
		end
		gck = 1'b1;
		pins = '0;
		map(0, 1'b1, 0, 2'h2);
		role(2'h1, 1'b1, 1'b0);
		role(2'h2, 1'b0, 1'b1);
		role(2'h0, 1'b1, 1'b1);
		role(2'h0, 1'b0, 1'b0);
		// Low glitch shorter than the gap: roles cannot be judged
		kind = 2'h1;
		pins[0] = 1'b1;
		step(20);
		pins[0] = 1'b0;
		step(2);
		pins[0] = 1'b1;
		step(20);
		cmp(8'(act[0]), 8'h01);
		gck = 1'b0;
		ipd = 6'h2A;
		for (int s = 0; s < 4; s++) begin
			gcs = 2'(s);
			pins[0] = 1'b0;
			apply;
			base_pc = n_pc;
			base_pd = n_pd;
			pins[0] = 1'b1;
			step(20);
			cmp(8'(pdf[0]), 8'(s == 1));
			cmp(8'(pdc), (s == 1) ? 8'h2A : 8'h00);
			pins[0] = 1'b0;
			step(20);
			cmp(8'(n_pc - base_pc), 8'(s > 1));
			cmp(8'(n_pd - base_pd), 8'(s > 0));
		end
		gcs = 2'h0;
		pins = 3'h3;
		sel[0] = 3'h2;
		sel[1] = 3'h2;
		en = 3'h3;
		mode = '0;
		mode[2] = 2'h1;
		apply;
		cmp(hs | ls, 8'h00);
		cmp(err, 8'h04);
		cmp(8'(spi), 8'h01);
		en = 3'h1;
		apply;
		clr = 8'h04;
		step(1);
		clr = 8'h00;
		step(12);
		cmp(err, 8'h00);
		cmp(8'(spi), 8'h00);
		cmp(ls, 8'h04);
		pass = 1'b1;
		apply;
		cmp(hs | ls, 8'h00);
		pass = 1'b0;
		apply;
		step(12);
		cmp(ls, 8'h04);
		print_verdict;
	end
endmodule
`default_nettype wire
